// >>> pkg/irq_enable_pkg.sv
// Constants and types shared by the interrupt enable bank
`default_nettype none
package irq_enable_pkg;

    // Bank geometry
    localparam int NUM_REGS = 4;
    localparam int REG_W    = 16;
    localparam int NUM_SRC  = NUM_REGS * REG_W;
    localparam int PRIO_W   = 3;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_ENABLE_0 = 8'h00;
    localparam logic [7:0] OFS_ENABLE_3 = 8'h0C;
    localparam logic [7:0] OFS_FLAG_0   = 8'h10;
    localparam logic [7:0] OFS_FLAG_3   = 8'h1C;
    localparam logic [7:0] OFS_PRIO_0   = 8'h20;
    localparam logic [7:0] OFS_PRIO_7   = 8'h3C;
    localparam logic [7:0] OFS_STATUS   = 8'h40;
    localparam logic [7:0] OFS_MASK     = 8'h44;
    localparam logic [7:0] OFS_REQUEST  = 8'h48;

    // Implemented bit positions of each enable and flag register
    localparam logic [REG_W-1:0] IMPL_REG_0 = 16'h7FFF;
    localparam logic [REG_W-1:0] IMPL_REG_1 = 16'hFFDF;
    localparam logic [REG_W-1:0] IMPL_REG_2 = 16'h601F;
    localparam logic [REG_W-1:0] IMPL_REG_3 = 16'h6000;
    // Controller-area-network bits of enable_reg_2
    localparam logic [REG_W-1:0] CAN_BITS_2 = 16'h000C;

    // Named bit positions
    localparam int BIT_OUT_CMP1   = 2;
    localparam int BIT_IN_CAP1    = 1;
    localparam int BIT_EXT_IRQ0   = 0;
    localparam int BIT_UART2_TX   = 15;
    localparam int BIT_DMA_CH2    = 8;
    localparam int BIT_DMA_CH4    = 14;
    localparam int BIT_CALENDAR   = 14;

    // Reset values
    localparam logic [REG_W-1:0]  ENABLE_RESET = 16'h0000;
    localparam logic [REG_W-1:0]  FLAG_RESET   = 16'h0000;
    localparam logic [PRIO_W-1:0] PRIO_RESET   = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_OFF     = 3'h0;

    // Status and mask layout
    localparam int STAT_W       = 2;
    localparam int STAT_NEW_REQ = 0;
    localparam int STAT_NEW_FLG = 1;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

    // Priority words hold eight four-bit fields, three bits used
    localparam int PRIO_PER_WORD = 8;
    localparam int PRIO_FIELD_W  = 4;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD} bus_state_t;

endpackage

`default_nettype wire

// >>> core/gate_row.sv
// Request qualification for one enable register row
`timescale 1ns/1ps
`default_nettype none

module gate_row
    import irq_enable_pkg::*;
#(
    parameter int W = REG_W
)(
    // Row state
    input  wire logic [W-1:0]             flag_row,
    input  wire logic [W-1:0]             en_row,
    input  wire logic [W-1:0][PRIO_W-1:0] prio_row,
    // Qualified requests
    output logic      [W-1:0]             qual_row
);

    genvar b;
    generate
        for (b = 0; b < W; b++)
        begin : g_bit
            // Zero priority is a disable even with the enable set
            assign qual_row[b] = flag_row[b] & en_row[b] & (prio_row[b] != PRIO_OFF);
        end
    endgenerate

endmodule // gate_row

`default_nettype wire

// >>> core/irq_enable_bank.sv
// Interrupt enable bank with flags, priorities and an AHB-Lite register slave
//
// Overview of operation
// - Implemented enable bits are read/write; one passes the request, zero blocks it.
// - Unimplemented enable bits ignore writes and read back zero.
// - All enable bits clear at reset, so every source starts disabled.
// - Without the CAN controller its enable bits do nothing and stay zero.
// - Register 1 bits 15..8: uart2 tx/rx, ext irq2, timer5/4, cmp4/3, dma2.
// - Register 1 bits 7,6 capture 8,7; bit 5 unused; 4..0 ext1,cn,cmp,i2c.
// - Register 2 bits 14,13 dma4, parallel port; 4..0 dma3, can, spi2; rest unused.
// - Register 3 bit 14 calendar clock, bit 13 dma5; all other bits unused.
// - Register 0 bit 2 compare 1, bit 1 capture 1, bit 0 external irq 0.
// - Each source owns a flag at the same position, set once it requests.
// - Priority field zero disables the source; one to seven are priorities.
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module irq_enable_bank
    import irq_enable_pkg::*;
#(
    parameter bit CAN_PRESENT = 1'b1
)(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Peripheral request sources
    input  wire logic [NUM_SRC-1:0]        src_req,
    // Toward priority arbitration
    output logic      [NUM_SRC-1:0]        req_out,
    output logic      [NUM_SRC-1:0][PRIO_W-1:0] req_prio,
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        bus_state_t                       bus;
        logic [7:0]                       addr;
        logic [31:0]                      hrdata;
        logic                             hready;
        logic [NUM_REGS-1:0][REG_W-1:0]   en;
        logic [NUM_REGS-1:0][REG_W-1:0]   flag;
        logic [NUM_SRC-1:0][PRIO_W-1:0]   prio;
        logic [STAT_W-1:0]                status;
        logic [STAT_W-1:0]                mask;
        logic [NUM_SRC-1:0]               req;
        logic                             irq;
    } bank_state_t;

    bank_state_t st_ff;
    bank_state_t nxt_st;

    logic [NUM_REGS-1:0][REG_W-1:0] impl;
    logic [NUM_SRC-1:0]             impl_flat;
    logic [NUM_SRC-1:0]             en_flat;
    logic [NUM_SRC-1:0]             flag_flat;
    logic [NUM_SRC-1:0]             qual;
    logic [NUM_SRC-1:0]             prio_nz;
    logic                           accept;
    logic [31:0]                    rd_data;

    // Missing CAN hardware removes its bits from the implemented set
    assign impl[0] = IMPL_REG_0;
    assign impl[1] = IMPL_REG_1;
    assign impl[2] = CAN_PRESENT ? IMPL_REG_2 : (IMPL_REG_2 & ~CAN_BITS_2);
    assign impl[3] = IMPL_REG_3;

    assign impl_flat = impl;
    assign en_flat   = st_ff.en;
    assign flag_flat = st_ff.flag;

    assign accept = hsel && htrans[1] && hready && st_ff.hready;

    ////////////////////////////////////////////////////////////////////////////
    // Qualification, one row per enable register

    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++)
        begin : g_row
            gate_row #(
                .W (REG_W)
            ) u_row (
                .flag_row (st_ff.flag[r]),
                .en_row   (st_ff.en[r]),
                .prio_row (st_ff.prio[r*REG_W +: REG_W]),
                .qual_row (qual[r*REG_W +: REG_W])
            );
        end
        for (r = 0; r < NUM_SRC; r++)
        begin : g_nz
            assign prio_nz[r] = (st_ff.prio[r] != PRIO_OFF);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (st_ff.addr >= OFS_ENABLE_0 && st_ff.addr <= OFS_ENABLE_3)
        begin
            rd_data[REG_W-1:0] = st_ff.en[st_ff.addr[3:2]] & impl[st_ff.addr[3:2]];
        end
        else if (st_ff.addr >= OFS_FLAG_0 && st_ff.addr <= OFS_FLAG_3)
        begin
            rd_data[REG_W-1:0] = st_ff.flag[st_ff.addr[3:2]] & impl[st_ff.addr[3:2]];
        end
        else if (st_ff.addr >= OFS_PRIO_0 && st_ff.addr <= OFS_PRIO_7)
        begin
            for (int j = 0; j < PRIO_PER_WORD; j++)
            begin
                rd_data[j*PRIO_FIELD_W +: PRIO_W] = st_ff.prio[{st_ff.addr[4:2], j[2:0]}];
            end
        end
        else if (st_ff.addr == OFS_STATUS)
        begin
            rd_data[STAT_W-1:0] = st_ff.status;
        end
        else if (st_ff.addr == OFS_MASK)
        begin
            rd_data[STAT_W-1:0] = st_ff.mask;
        end
        else if (st_ff.addr == OFS_REQUEST)
        begin
            rd_data[0] = |st_ff.req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_st = st_ff;

        case (st_ff.bus)
            BUS_WR:
            begin
                // Writes land in the data phase, zero wait states
                if (st_ff.addr >= OFS_ENABLE_0 && st_ff.addr <= OFS_ENABLE_3)
                begin
                    // Flags are left alone when an enable is cleared
                    nxt_st.en[st_ff.addr[3:2]] = hwdata[REG_W-1:0] & impl[st_ff.addr[3:2]];
                end
                else if (st_ff.addr >= OFS_FLAG_0 && st_ff.addr <= OFS_FLAG_3)
                begin
                    nxt_st.flag[st_ff.addr[3:2]] = hwdata[REG_W-1:0] & impl[st_ff.addr[3:2]];
                end
                else if (st_ff.addr >= OFS_PRIO_0 && st_ff.addr <= OFS_PRIO_7)
                begin
                    for (int j = 0; j < PRIO_PER_WORD; j++)
                    begin
                        nxt_st.prio[{st_ff.addr[4:2], j[2:0]}] = hwdata[j*PRIO_FIELD_W +: PRIO_W];
                    end
                end
                else if (st_ff.addr == OFS_STATUS)
                begin
                    nxt_st.status = st_ff.status & ~hwdata[STAT_W-1:0];
                end
                else if (st_ff.addr == OFS_MASK)
                begin
                    nxt_st.mask = hwdata[STAT_W-1:0];
                end
            end
            BUS_RD:
            begin
                // One wait state so a read never misses the write just before it
                nxt_st.hrdata = rd_data;
                nxt_st.hready = 1'b1;
            end
            default:
            begin
            end
        endcase

        nxt_st.bus = BUS_IDLE;
        if (accept)
        begin
            nxt_st.addr   = haddr;
            nxt_st.bus    = hwrite ? BUS_WR : BUS_RD;
            nxt_st.hready = hwrite;
        end

        // Hardware sets win over a software clear in the same cycle
        nxt_st.flag = nxt_st.flag | (src_req & impl_flat);
        nxt_st.status[STAT_NEW_REQ] = nxt_st.status[STAT_NEW_REQ] | (|(qual & ~st_ff.req));
        nxt_st.status[STAT_NEW_FLG] = nxt_st.status[STAT_NEW_FLG] | (|(src_req & impl_flat & ~flag_flat));

        nxt_st.req = qual;
        nxt_st.irq = |(st_ff.status & st_ff.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_ff.bus    <= BUS_IDLE;
            st_ff.addr   <= 8'h00;
            st_ff.hrdata <= 32'h0000_0000;
            st_ff.hready <= 1'b1;
            st_ff.en     <= {NUM_REGS{ENABLE_RESET}};
            st_ff.flag   <= {NUM_REGS{FLAG_RESET}};
            st_ff.prio   <= {NUM_SRC{PRIO_RESET}};
            st_ff.status <= STAT_RESET;
            st_ff.mask   <= STAT_RESET;
            st_ff.req    <= {NUM_SRC{1'b0}};
            st_ff.irq    <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata    = st_ff.hrdata;
    assign hreadyout = st_ff.hready;
    assign hresp     = 1'b0;
    assign req_out   = st_ff.req;
    assign req_prio  = st_ff.prio;
    assign irq       = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_clears_en: assert property ($past(reset) |-> (en_flat == {NUM_SRC{1'b0}}))
        else $error("enable bits not zero after reset");
    a_unimpl_reads_zero: assert property ((en_flat & ~impl_flat) == {NUM_SRC{1'b0}})
        else $error("unimplemented enable bit set");
    a_can_bits_dead: assert property (!CAN_PRESENT |-> ((st_ff.en[2] & CAN_BITS_2) == 16'h0000))
        else $error("CAN enable bit set without CAN hardware");
    a_req_needs_enable: assert property ((req_out & ~$past(en_flat)) == {NUM_SRC{1'b0}})
        else $error("request passed with enable clear");
    a_req_needs_flag: assert property ((req_out & ~$past(flag_flat)) == {NUM_SRC{1'b0}})
        else $error("request passed with flag clear");
    a_zero_prio_blocks: assert property ((req_out & ~$past(prio_nz)) == {NUM_SRC{1'b0}})
        else $error("request passed with priority zero");
    a_flag_catches_req: assert property (((src_req & impl_flat) != {NUM_SRC{1'b0}})
        |=> ((flag_flat & $past(src_req & impl_flat)) == $past(src_req & impl_flat)))
        else $error("flag missed a source request");
    a_en_clear_keeps_flag: assert property ((st_ff.bus == BUS_WR && st_ff.addr <= OFS_ENABLE_3)
        |=> (($past(flag_flat) & ~flag_flat) == {NUM_SRC{1'b0}}))
        else $error("enable write cleared a flag");
    a_en_write_stores: assert property ((st_ff.bus == BUS_WR && st_ff.addr <= OFS_ENABLE_3)
        |=> (st_ff.en[$past(st_ff.addr[3:2])] == ($past(hwdata[REG_W-1:0]) & impl[$past(st_ff.addr[3:2])])))
        else $error("enable write not stored");
    a_map_bits_held: assert property (impl[0][BIT_OUT_CMP1] && impl[0][BIT_IN_CAP1] && impl[0][BIT_EXT_IRQ0]
        && impl[1][BIT_UART2_TX] && impl[1][BIT_DMA_CH2] && !impl[1][5] && impl[2][BIT_DMA_CH4]
        && impl[3][BIT_CALENDAR] && (impl[3] & 16'h9FFF) == 16'h0000)
        else $error("enable bit map wrong");
    a_read_one_wait: assert property ((st_ff.bus == BUS_RD) |-> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_req_passes: cover property (src_req[BIT_EXT_IRQ0] ##2 req_out[BIT_EXT_IRQ0]);
    c_en_cleared: cover property (st_ff.bus == BUS_WR && st_ff.addr == OFS_ENABLE_0 && hwdata == 32'h0000_0000);
    c_read_done: cover property (st_ff.bus == BUS_RD ##1 hreadyout);
    c_irq_rise: cover property (!irq ##1 irq);

endmodule // irq_enable_bank

`default_nettype wire

// >>> testbench/req_source.sv
// Peripheral request source model driving the level request lines
`timescale 1ns/1ps
`default_nettype none

module req_source
    import irq_enable_pkg::*;
(
    // Clock
    input  wire logic                clk,
    // Requests toward the bank
    output logic      [NUM_SRC-1:0]  src_req
);
    initial src_req = '0;

    // A one-cycle pulse is enough, the flag holds it afterwards
    task automatic fire(input int idx);
        begin
            @(posedge clk);
            src_req[idx] <= 1'b1;
            @(posedge clk);
            src_req[idx] <= 1'b0;
        end
    endtask
endmodule // req_source
`default_nettype wire

// >>> testbench/tb_irq_enable_bank.sv
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
`default_nettype none

module tb_irq_enable_bank
    import irq_enable_pkg::*;
();

    logic                           clk = 1'b0;
    logic                           reset = 1'b1;
    logic                           hsel = 1'b0;
    logic [7:0]                     haddr = 8'h00;
    logic [1:0]                     htrans = 2'h0;
    logic                           hwrite = 1'b0;
    logic [31:0]                    hwdata = 32'h0;
    logic [31:0]                    hrdata;
    logic [31:0]                    hrdata_b;
    logic [31:0]                    rd_b;
    logic [31:0]                    q;
    logic                           hreadyout;
    logic                           hready_b;
    logic                           hresp;
    logic                           irq;
    logic [NUM_SRC-1:0]             src_req;
    logic [NUM_SRC-1:0]             req_out;
    logic [NUM_SRC-1:0][PRIO_W-1:0] req_prio;
    int                             bad_count = 0;
    int                             samples_checked = 0;

    localparam logic [7:0]  R_A [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h48, 8'h80, 8'h00, 8'h04, 8'h08, 8'h0C};
    localparam logic [31:0] R_D [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
                                        32'hFFFFFFFF, 32'hFFFFFFFF};
    localparam logic [31:0] R_E [6] = '{32'h7FFF, 32'hFFDF, 32'h601F, 32'h6000, 32'h0, 32'h0};

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    irq_enable_bank irq_enable_bank_inst (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .src_req(src_req), .req_out(req_out), .req_prio(req_prio), .irq(irq));
    // Variant without the CAN controller shares the bus, only its read data is watched
    irq_enable_bank #(.CAN_PRESENT(1'b0)) irq_enable_bank_b_inst (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready_b), .hrdata(hrdata_b), .hreadyout(hready_b),
        .hresp(), .src_req(src_req), .req_out(), .req_prio(), .irq());
    req_source req_source_inst (.clk(clk), .src_req(src_req));

    ////////////////////////////////////////////////////////////////////////////////
    // Wide enough for the whole request vector
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        begin
            samples_checked++;
            if (got !== exp)
            begin
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
                bad_count++;
            end
        end
    endtask

    // Single AHB-Lite transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            q = hrdata;
            rd_b = hrdata_b;
            chk(hresp, 1'b0);
        end
    endtask

    task automatic test_done;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        bad_count++;
        test_done;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(req_out, 64'h0);
        chk(req_prio[0], 3'h4);
        chk(irq, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, R_A[i], 32'h0);
            chk(q, 32'h0);
        end
        $display("reset values done");
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, R_A[i], (i < 6) ? R_D[i] : 32'h0);
            bus(1'b0, R_A[i], 32'h0);
            chk(q, (i < 6) ? R_E[i] : 32'h0);
            if (i == 2)
                chk(rd_b, 32'h6013);
        end
        $display("register rows done");
        bus(1'b1, 8'h44, 32'h3);
        bus(1'b1, 8'h00, 32'h1);
        req_source_inst.fire(0);
        repeat (4) @(posedge clk);
        chk(req_out[0], 1'b1);
        chk(irq, 1'b1);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h3);
        bus(1'b1, 8'h40, 32'h3);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge clk);
        chk(req_out[0], 1'b0);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h1);
        $display("request gating done");
        bus(1'b1, 8'h20, 32'h44444440);
        bus(1'b1, 8'h00, 32'h1);
        repeat (2) @(posedge clk);
        chk(req_out[0], 1'b0);
        chk(req_prio[0], 3'h0);
        bus(1'b1, 8'h20, 32'h44444447);
        repeat (2) @(posedge clk);
        chk(req_out[0], 1'b1);
        chk(req_prio[0], 3'h7);
        bus(1'b0, 8'h48, 32'h0);
        chk(q, 32'h1);
        $display("priority done");
        bus(1'b1, 8'h44, 32'h0);
        req_source_inst.fire(1);
        repeat (4) @(posedge clk);
        chk(req_out[1], 1'b0);
        chk(irq, 1'b0);
        bus(1'b0, 8'h40, 32'h0);
        chk(q & 32'h2, 32'h2);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h3);
        $display("mask done");
        // Reset in mid-run with source 0 enabled, flagged and at priority 7
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(req_out, 64'h0);
        chk(req_prio[0], 3'h4);
        chk(irq, 1'b0);
        bus(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        $display("mid-run reset done");
        test_done;
    end
endmodule // tb_irq_enable_bank
`default_nettype wire
